// File: hw/emb_block.sv
// Configurable embedded memory block with APB configuration port
`timescale 1ns/100ps

module emb_block (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [emb_pkg::EMB_APB_AW-1:0] paddr,
   input wire logic [emb_pkg::EMB_APB_DW-1:0] pwdata,
   output logic [emb_pkg::EMB_APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mem_clr,
   input wire logic blk_sel,
   input wire logic wr_clk_en,
   input wire logic rd_clk_en,
   input wire logic [emb_pkg::EMB_ADDR_W-1:0] wr_addr,
   input wire logic [emb_pkg::EMB_DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic [emb_pkg::EMB_ADDR_W-1:0] rd_addr,
   input wire logic rd_en,
   output logic [emb_pkg::EMB_DATA_W-1:0] rd_data
);
   import emb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Address and lane arithmetic shared by write and read paths

   // Physical row of a word address
   function automatic logic [EMB_ROW_W-1:0] emb_row(
      input logic [EMB_ADDR_W-1:0] a,
      input emb_shape_t s
   );
      emb_row = EMB_ROW_W'(a >> s);
   endfunction

   // Slice index inside the row, from the low address bits
   function automatic logic [EMB_SLICE_W-1:0] emb_slice(
      input logic [EMB_ADDR_W-1:0] a,
      input emb_shape_t s
   );
      logic [EMB_SLICE_W-1:0] low;
      low = EMB_SLICE_W'((1 << s) - 1);
      emb_slice = EMB_SLICE_W'(a) & low;
   endfunction

   // Bits of one slice of the given shape
   function automatic int emb_lane_w(input emb_shape_t s);
      emb_lane_w = EMB_DATA_W >> s;
   endfunction

   // Write mask for one slice
   function automatic logic [EMB_DATA_W-1:0] emb_mask(
      input logic [EMB_SLICE_W-1:0] sl,
      input emb_shape_t s
   );
      logic [EMB_DATA_W-1:0] ones;
      ones = EMB_DATA_W'((1 << emb_lane_w(s)) - 1);
      emb_mask = EMB_DATA_W'(ones << (int'(sl) * emb_lane_w(s)));
   endfunction

   // Narrow write data copied into every lane; the mask picks one
   function automatic logic [EMB_DATA_W-1:0] emb_spread(
      input logic [EMB_DATA_W-1:0] d,
      input emb_shape_t s
   );
      emb_spread = '0;
      for (int i = 0; i < EMB_DATA_W; i++) begin
         emb_spread[i] = d[i % emb_lane_w(s)];
      end
   endfunction

   // Slice of a row word, right aligned, upper bits zero
   function automatic logic [EMB_DATA_W-1:0] emb_pick(
      input logic [EMB_DATA_W-1:0] q,
      input logic [EMB_SLICE_W-1:0] sl,
      input emb_shape_t s
   );
      logic [EMB_DATA_W-1:0] ones;
      ones = EMB_DATA_W'((1 << emb_lane_w(s)) - 1);
      emb_pick = EMB_DATA_W'(q >> (int'(sl) * emb_lane_w(s))) & ones;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB configuration registers

   emb_cfg_t cfg;
   emb_cfg_t next_cfg;
   logic [EMB_ROW_W-1:0] pre_row;
   logic [EMB_ROW_W-1:0] next_pre_row;
   logic [EMB_CNT_W-1:0] wr_count;
   logic [EMB_CNT_W-1:0] next_wr_count;
   logic [EMB_APB_DW-1:0] next_prdata;
   logic next_pslverr;
   logic apb_setup;
   logic apb_wr;
   logic pre_wr;
   logic user_wr;
   logic mapped;

   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite;
   // Preload only before the lock; afterwards only user writes change contents
   assign pre_wr = apb_wr && (paddr == EMB_OFS_PRE_DATA) && !cfg.lock;
   assign mapped = (paddr == EMB_OFS_CTRL) || (paddr == EMB_OFS_STATUS) ||
      (paddr == EMB_OFS_PRE_ROW) || (paddr == EMB_OFS_PRE_DATA);

   // Next register values; configuration freezes once locked
   always_comb begin
      next_cfg = cfg;
      next_pre_row = pre_row;
      next_wr_count = wr_count;
      if (apb_wr && !cfg.lock && (paddr == EMB_OFS_CTRL)) begin
         next_cfg = emb_cfg_t'(pwdata[EMB_CFG_W-1:0]);
      end
      if (apb_wr && (paddr == EMB_OFS_PRE_ROW)) begin
         next_pre_row = pwdata[EMB_ROW_W-1:0];
      end else if (pre_wr) begin
         next_pre_row = EMB_ROW_W'(pre_row + 1'b1);
      end
      if (user_wr) begin
         next_wr_count = EMB_CNT_W'(wr_count + 1'b1);
      end
   end

   // Read data captured in setup so it leaves a flip-flop
   always_comb begin
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (apb_setup) begin
         next_pslverr = !mapped;
         next_prdata = EMB_ZERO_WORD;
         if (!pwrite) begin
            case (paddr)
               EMB_OFS_CTRL: begin
                  next_prdata[EMB_CFG_W-1:0] = cfg;
               end
               EMB_OFS_STATUS: begin
                  next_prdata[EMB_STAT_LOCK] = cfg.lock;
                  next_prdata[EMB_STAT_ROM] = cfg.rom;
                  next_prdata[EMB_STAT_CNT_LSB +: EMB_CNT_W] = wr_count;
               end
               EMB_OFS_PRE_ROW: begin
                  next_prdata[EMB_ROW_W-1:0] = pre_row;
               end
               default: begin
                  next_prdata = EMB_ZERO_WORD;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= emb_cfg_t'(EMB_CFG_RESET);
         pre_row <= '0;
         prdata <= EMB_ZERO_WORD;
         pslverr <= 1'b0;
      end else begin
         cfg <= next_cfg;
         pre_row <= next_pre_row;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // No wait states; every access completes in its first access cycle
   assign pready = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Datapath clear: reset or user clear, both asynchronous
   // Clear is combined with reset, so it must come glitch free

   logic dp_rst_n;
   assign dp_rst_n = presetn && !mem_clr;

   // Write count shares the datapath clear
   always_ff @(posedge pclk or negedge dp_rst_n) begin
      if (!dp_rst_n) begin
         wr_count <= '0;
      end else begin
         wr_count <= next_wr_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Section enables; one clock, slower rates come as enables

   logic ce_wr;
   logic ce_rd_in;
   logic ce_out;

   assign ce_wr = wr_clk_en;
   // Input-output scheme moves read input registers to the first pair
   assign ce_rd_in = cfg.io_clk ? wr_clk_en : rd_clk_en;
   assign ce_out = rd_clk_en;

   ////////////////////////////////////////////////////////////////////////
   // Input stages, each registered or bypassed on its own

   logic [EMB_DATA_W-1:0] wdata_s;
   logic [EMB_ADDR_W-1:0] waddr_s;
   logic we_s;
   logic [EMB_ADDR_W-1:0] raddr_s;
   logic re_s;

   // Select gates the write enable so cascaded blocks decode upper address
   emb_stage #(.W(EMB_DATA_W)) u_wdata (
      .clk(pclk),
      .rst_n(dp_rst_n),
      .en(ce_wr),
      .reg_on(cfg.reg_wdata),
      .d(wr_data),
      .q(wdata_s)
   );
   emb_stage #(.W(EMB_ADDR_W)) u_waddr (
      .clk(pclk),
      .rst_n(dp_rst_n),
      .en(ce_wr),
      .reg_on(cfg.reg_waddr),
      .d(wr_addr),
      .q(waddr_s)
   );
   emb_stage #(.W(1)) u_we (
      .clk(pclk),
      .rst_n(dp_rst_n),
      .en(ce_wr),
      .reg_on(cfg.reg_we),
      .d(wr_en && blk_sel),
      .q(we_s)
   );
   emb_stage #(.W(EMB_ADDR_W)) u_raddr (
      .clk(pclk),
      .rst_n(dp_rst_n),
      .en(ce_rd_in),
      .reg_on(cfg.reg_raddr),
      .d(cfg.dual ? rd_addr : wr_addr),
      .q(raddr_s)
   );
   emb_stage #(.W(1)) u_re (
      .clk(pclk),
      .rst_n(dp_rst_n),
      .en(ce_rd_in),
      .reg_on(cfg.reg_re),
      .d(rd_en),
      .q(re_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Array access

   emb_mem_if mif ();
   logic arr_rd;
   logic [EMB_SLICE_W-1:0] rd_slice;
   logic [EMB_SLICE_W-1:0] next_rd_slice;
   logic rd_hit;
   logic next_rd_hit;
   logic rd_sel;

   // Write strobe made here on the write edge, never by the user
   assign user_wr = ce_wr && we_s && cfg.lock && !cfg.rom;
   assign arr_rd = ce_rd_in && re_s;
   assign rd_sel = blk_sel;

   // Preload writes whole rows; user writes touch one slice
   always_comb begin
      mif.wr_en = user_wr || pre_wr;
      mif.wr_row = cfg.lock ? emb_row(waddr_s, cfg.shape) : pre_row;
      mif.wr_data = cfg.lock ? emb_spread(wdata_s, cfg.shape) :
         pwdata[EMB_DATA_W-1:0];
      mif.wr_mask = cfg.lock ?
         emb_mask(emb_slice(waddr_s, cfg.shape), cfg.shape) : '1;
      mif.rd_en = arr_rd;
      mif.rd_row = emb_row(raddr_s, cfg.shape);
   end

   // Slice and select travel with the array read word
   always_comb begin
      next_rd_slice = arr_rd ? emb_slice(raddr_s, cfg.shape) : rd_slice;
      next_rd_hit = arr_rd ? rd_sel : rd_hit;
   end

   always_ff @(posedge pclk or negedge dp_rst_n) begin
      if (!dp_rst_n) begin
         rd_slice <= '0;
         rd_hit <= 1'b0;
      end else begin
         rd_slice <= next_rd_slice;
         rd_hit <= next_rd_hit;
      end
   end

   emb_array u_array (
      .clk(pclk),
      .rst_n(dp_rst_n),
      .m(mif.ctl)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output stage; a block deselected at its array read drives zero so outputs can be ORed
   // In read-only mode with the x16 shape an 8-bit address yields a 16-bit table word

   logic [EMB_DATA_W-1:0] rd_word;
   assign rd_word = rd_hit ?
      emb_pick(mif.rd_q, rd_slice, cfg.shape) : '0;

   emb_stage #(.W(EMB_DATA_W)) u_rdata (
      .clk(pclk),
      .rst_n(dp_rst_n),
      .en(ce_out),
      .reg_on(cfg.reg_rdata),
      .d(rd_word),
      .q(rd_data)
   );
endmodule

// File: common/emb_pkg.sv
// Shared constants, types and configuration layout of the memory block
package emb_pkg;

   // Storage geometry: one physical row holds the widest word
   localparam int EMB_TOTAL_BITS = 4096;
   localparam int EMB_DATA_W = 16;
   localparam int EMB_ROWS = EMB_TOTAL_BITS / EMB_DATA_W;
   localparam int EMB_ROW_W = $clog2(EMB_ROWS);
   localparam int EMB_ADDR_W = 11;
   localparam int EMB_SLICE_W = 3;

   // Word shape; the code equals log2 of the slices per row
   typedef enum logic [1:0] {
      EMB_X16 = 2'b00,
      EMB_X8 = 2'b01,
      EMB_X4 = 2'b10,
      EMB_X2 = 2'b11
   } emb_shape_t;

   // Configuration word as held in the control register
   typedef struct packed {
      logic lock;
      logic reg_re;
      logic reg_raddr;
      logic reg_we;
      logic reg_waddr;
      logic reg_rdata;
      logic reg_wdata;
      logic rom;
      logic io_clk;
      logic dual;
      emb_shape_t shape;
   } emb_cfg_t;

   localparam int EMB_CFG_W = $bits(emb_cfg_t);
   // Dual port, 256 x 16, every path registered, unlocked
   localparam logic [EMB_CFG_W-1:0] EMB_CFG_RESET = 12'h7E4;

   // APB map
   localparam int EMB_APB_AW = 12;
   localparam int EMB_APB_DW = 32;
   localparam logic [EMB_APB_AW-1:0] EMB_OFS_CTRL = 12'h000;
   localparam logic [EMB_APB_AW-1:0] EMB_OFS_STATUS = 12'h004;
   localparam logic [EMB_APB_AW-1:0] EMB_OFS_PRE_ROW = 12'h008;
   localparam logic [EMB_APB_AW-1:0] EMB_OFS_PRE_DATA = 12'h00C;

   // Status fields
   localparam int EMB_STAT_LOCK = 0;
   localparam int EMB_STAT_ROM = 1;
   localparam int EMB_STAT_CNT_LSB = 16;
   localparam int EMB_CNT_W = 16;
   localparam logic [EMB_APB_DW-1:0] EMB_ZERO_WORD = 32'h0000_0000;

endpackage

// File: common/emb_mem_if.sv
// Connection between block control logic and its storage array
`timescale 1ns/100ps
interface emb_mem_if;
   logic wr_en;
   logic [emb_pkg::EMB_ROW_W-1:0] wr_row;
   logic [emb_pkg::EMB_DATA_W-1:0] wr_data;
   logic [emb_pkg::EMB_DATA_W-1:0] wr_mask;
   logic rd_en;
   logic [emb_pkg::EMB_ROW_W-1:0] rd_row;
   logic [emb_pkg::EMB_DATA_W-1:0] rd_q;

   modport ctl (
      output wr_en, wr_row, wr_data, wr_mask, rd_en, rd_row,
      input rd_q
   );
   modport arr (
      input wr_en, wr_row, wr_data, wr_mask, rd_en, rd_row,
      output rd_q
   );
endinterface

// File: hw/emb_array.sv
// Storage array with bit-masked write and registered read word
`timescale 1ns/100ps
module emb_array (
   input wire logic clk,
   input wire logic rst_n,
   emb_mem_if.arr m
);
   import emb_pkg::*;

   logic [EMB_DATA_W-1:0] mem [EMB_ROWS];
   logic [EMB_DATA_W-1:0] next_word;
   logic [EMB_DATA_W-1:0] q;
   logic [EMB_DATA_W-1:0] next_q;

   ////////////////////////////////////////////////////////////////////////
   // Only the masked slice changes, so narrow slices never overlap
   always_comb begin
      next_word = (mem[m.wr_row] & ~m.wr_mask) | (m.wr_data & m.wr_mask);
   end

   // Contents carry no reset; a clear must not wipe preloaded tables
   always_ff @(posedge clk) begin
      if (m.wr_en) begin
         mem[m.wr_row] <= next_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read sees the old word when the same row is written this edge
   always_comb begin
      next_q = m.rd_en ? mem[m.rd_row] : q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign m.rd_q = q;
endmodule

// File: hw/emb_stage.sv
// Optional register stage with clock enable and bypass
`timescale 1ns/100ps
module emb_stage #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic reg_on,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] r;
   logic [W-1:0] next_r;

   ////////////////////////////////////////////////////////////////////////
   // Hold when the section enable is low
   always_comb begin
      next_r = en ? d : r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Bypass passes the path through with no added cycle
   assign q = reg_on ? r : d;
endmodule

// File: sim/emb_block_properties.sv
// Port-level properties of the embedded memory block
`timescale 1ns/100ps
module emb_block_properties
   import emb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [emb_pkg::EMB_APB_AW-1:0] paddr,
   input wire logic [emb_pkg::EMB_APB_DW-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mem_clr,
   input wire logic blk_sel,
   input wire logic rd_clk_en,
   input wire logic rd_en,
   input wire logic [emb_pkg::EMB_DATA_W-1:0] rd_data
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic unm;
   logic setup;
   // Offsets outside the four mapped words
   assign unm = !(paddr inside {EMB_OFS_CTRL, EMB_OFS_STATUS,
      EMB_OFS_PRE_ROW, EMB_OFS_PRE_DATA});
   assign setup = psel && !penable;

   a_pready_high: assert property (pready)
      else $error("pready low");
   a_err_unmapped: assert property (setup && unm |=> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (setup && !unm |=> !pslverr)
      else $error("error on mapped access");
   a_unmapped_zero: assert property (setup && unm && !pwrite
      |=> prdata == EMB_ZERO_WORD)
      else $error("unmapped read not zero");
   a_clear_zero: assert property (mem_clr |-> rd_data == '0)
      else $error("clear left read data");
   a_stall_hold: assert property (!rd_clk_en && !mem_clr
      ##1 !mem_clr |-> $stable(rd_data))
      else $error("read data moved while stalled");
   // Select is taken with the array read, so zero follows a read
   a_desel_zero: assert property (rd_en && rd_clk_en
      ##1 !blk_sel && rd_clk_en ##1 rd_clk_en |=> rd_data == '0)
      else $error("deselected block drives data");
   a_idle_hold: assert property ((!rd_en && blk_sel
      && !mem_clr) [*5] |-> $stable(rd_data))
      else $error("read data moved without read");

   c_read: cover property (rd_en && blk_sel && rd_clk_en);
   c_clear: cover property (mem_clr);
   c_unmapped: cover property (psel && penable && pslverr);
   c_desel: cover property (rd_en && !blk_sel);
endmodule

// File: sim/emb_user_model.sv
// User logic that drives the memory port of the block
`timescale 1ns/100ps
module emb_user_model (
   input wire logic pclk,
   output logic wr_en,
   output logic [10:0] wr_addr,
   output logic [15:0] wr_data,
   output logic rd_en,
   output logic [10:0] rd_addr,
   output logic [2:0] vld
);
   initial begin
      {wr_en, rd_en, wr_addr, wr_data, rd_addr, vld} = '0;
   end
   // Read tracker: data lands three enabled edges after the request
   always @(posedge pclk) begin
      vld <= {vld[1:0], rd_en};
   end
   // Released lines show inverted values so stale data never matches
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      @(posedge pclk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge pclk);
      wr_en <= 1'b0;
      wr_addr <= ~a;
      wr_data <= ~d;
   endtask
   task automatic rd(input logic [10:0] a);
      @(posedge pclk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge pclk);
      rd_en <= 1'b0;
      rd_addr <= ~a;
   endtask
   // Single-port read: the address rides on the write address lines
   task automatic srd(input logic [10:0] a);
      @(posedge pclk);
      rd_en <= 1'b1;
      wr_addr <= a;
      @(posedge pclk);
      rd_en <= 1'b0;
      wr_addr <= ~a;
   endtask
endmodule

// File: sim/emb_block_test.sv
// Self-checking bench for the embedded memory block
`timescale 1ns/100ps
bind emb_block emb_block_properties u_prop (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .mem_clr(mem_clr), .blk_sel(blk_sel), .rd_clk_en(rd_clk_en),
   .rd_en(rd_en), .rd_data(rd_data));
module emb_block_test;
   import emb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic mem_clr, blk_sel, wr_clk_en, rd_clk_en, wr_en, rd_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, cfg;
   logic [10:0] wr_addr, rd_addr, a;
   logic [15:0] wr_data, rd_data, msk;
   logic [15:0] exp_w [8];
   logic [15:0] expq [$];
   logic [2:0] vld;
   logic e;
   logic [7:0] p;
   int mismatches, compares;

   emb_block dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_clr(mem_clr), .blk_sel(blk_sel),
      .wr_clk_en(wr_clk_en), .rd_clk_en(rd_clk_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_addr(rd_addr),
      .rd_en(rd_en), .rd_data(rd_data));
   emb_user_model u_usr (.pclk(pclk), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .vld(vld));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task chk(input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task test_done;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // One APB transfer; the bound keeps a stuck slave from hanging us
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1) begin
         mismatches++;
         test_done();
      end
   endtask
   task rst;
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // Read results are compared against the oldest queued note
   always @(negedge pclk) begin
      if (vld[2] === 1'b1 && expq.size() > 0)
         chk({16'h0000, rd_data}, {16'h0000, expq.pop_front()});
   end
   initial begin
      repeat (100000) @(posedge pclk);
      mismatches++;
      test_done();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, mem_clr} = '0;
      {blk_sel, wr_clk_en, rd_clk_en} = 3'b111;
      void'($urandom(32'hfa1c));
      rst();
      apb(1'b0, EMB_OFS_CTRL, 32'h0000_0000);
      chk(r, {20'h0_0000, EMB_CFG_RESET});
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(r, EMB_ZERO_WORD);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      // Every shape: fill all slices of one row, read them back
      for (int s = 0; s < 4; s++) begin
         if (s > 0)
            rst();
         u_usr.wr(11'h7FF, 16'($urandom));
         cfg = 32'h0000_0FE4 | s;
         apb(1'b1, EMB_OFS_CTRL, cfg);
         apb(1'b1, EMB_OFS_CTRL, 32'h0000_07E4);
         apb(1'b0, EMB_OFS_CTRL, 32'h0000_0000);
         chk(r, cfg);
         msk = 16'hFFFF >> (16 - (16 >> s));
         a = 11'(8'($urandom) << s);
         for (int k = 0; k < (1 << s); k++) begin
            exp_w[k] = 16'($urandom);
            u_usr.wr(a + 11'(k), exp_w[k]);
            exp_w[k] = exp_w[k] & msk;
         end
         repeat (3) @(posedge pclk);
         for (int k = 0; k < (1 << s); k++) begin
            expq.push_back(exp_w[k]);
            u_usr.rd(a + 11'(k));
         end
         repeat (6) @(posedge pclk);
         apb(1'b0, EMB_OFS_STATUS, 32'h0000_0000);
         chk(r, ((1 << s) << 16) | 1);
      end
      // Deselected and stalled writes are lost, deselected read is 0
      blk_sel <= 1'b0;
      u_usr.wr(a, ~exp_w[0]);
      expq.push_back(16'h0000);
      u_usr.rd(a);
      repeat (6) @(posedge pclk);
      blk_sel <= 1'b1;
      wr_clk_en <= 1'b0;
      u_usr.wr(a, ~exp_w[0]);
      wr_clk_en <= 1'b1;
      rd_clk_en <= 1'b0;
      repeat (3) @(posedge pclk);
      rd_clk_en <= 1'b1;
      repeat (4) @(posedge pclk);
      expq.push_back(exp_w[0]);
      u_usr.rd(a);
      repeat (6) @(posedge pclk);
      // Clear empties the read path and the write count
      mem_clr <= 1'b1;
      @(posedge pclk);
      mem_clr <= 1'b0;
      chk({16'h0000, rd_data}, 32'h0000_0000);
      apb(1'b0, EMB_OFS_STATUS, 32'h0000_0000);
      chk(r, 32'h0000_0001);
      // Single port, io scheme, read output bypassed: data one edge early
      rst();
      apb(1'b1, EMB_OFS_CTRL, 32'h0000_0FA8);
      a = 11'($urandom);
      exp_w[0] = 16'($urandom);
      u_usr.wr(a, exp_w[0]);
      repeat (2) @(posedge pclk);
      u_usr.srd(a);
      @(posedge pclk);
      @(negedge pclk);
      chk({16'h0000, rd_data}, {16'h0000, exp_w[0]});
      // Preload two table rows, then lock as read-only
      rst();
      p = 8'($urandom);
      exp_w[0] = 16'($urandom);
      exp_w[1] = 16'($urandom);
      apb(1'b1, EMB_OFS_PRE_ROW, {24'h00_0000, p});
      apb(1'b1, EMB_OFS_PRE_DATA, {16'h0000, exp_w[0]});
      apb(1'b1, EMB_OFS_PRE_DATA, {16'h0000, exp_w[1]});
      apb(1'b1, EMB_OFS_CTRL, 32'h0000_0FF4);
      // Both of these must be refused once locked as a table
      apb(1'b1, EMB_OFS_PRE_DATA, 32'h0000_0000);
      u_usr.wr(11'(p), ~exp_w[0]);
      repeat (3) @(posedge pclk);
      for (int k = 0; k < 2; k++) begin
         expq.push_back(exp_w[k]);
         u_usr.rd(11'(p) + 11'(k));
      end
      repeat (6) @(posedge pclk);
      apb(1'b0, EMB_OFS_PRE_ROW, 32'h0000_0000);
      chk(r, {24'h00_0000, 8'(p + 8'h02)});
      apb(1'b0, EMB_OFS_STATUS, 32'h0000_0000);
      chk(r, 32'h0000_0003);
      // Every queued read note must have met its result
      chk(expq.size(), 32'h0000_0000);
      test_done();
   end
endmodule
